/* shared/aqcc_map.vh */
// Purpose: Constants for the analog quad channel control block.
// Assumes: One clock, registers reached over APB with 32-bit data.
// Notes: Offsets are byte addresses.
//
// Summary of operation
// - One temperature monitor per quad, differential between temperature and return pads.
// - Strobe switches between two diode excitation currents in ten-to-one ratio.
// - Driving the strobe to one starts a temperature measurement.
// - Control lines indexed by pad: 0 voltage, 1 current, 3 temperature.
// - Bits 2..0 select scaling; 000 is 0.15625, doubling to 20.0 at 111.
// - Bits 4..3 route input: prescaler, direct, monitor; 11 is invalid.
// - Bit 5 closes the direct input switch when one.
// - Bit 6 selects polarity: zero positive, one negative.
// - During boundary-scan extest the gate-drive pad stops driving, sinks current.
`ifndef AQCC_MAP_VH
`define AQCC_MAP_VH
`define AQCC_OFF_CH0 12'h000
`define AQCC_OFF_CH1 12'h004
`define AQCC_OFF_CH3 12'h00C
`define AQCC_OFF_TCTRL 12'h010
`define AQCC_OFF_STATUS 12'h014
`define AQCC_OFF_SAMPLE 12'h018
`define AQCC_CTL_W 7
`define AQCC_CTL_RESET 7'h00
`define AQCC_PRE_LSB 0
`define AQCC_PRE_MSB 2
`define AQCC_MUX_LSB 3
`define AQCC_MUX_MSB 4
`define AQCC_DIRECT_BIT 5
`define AQCC_POL_BIT 6
`define AQCC_PRE_16V 3'h0
`define AQCC_PRE_4V 3'h2
`define AQCC_MUX_INVALID 2'h3
`define AQCC_SAMPLE_RESET 8'h10
`define AQCC_SETUP_CYC 8'h01
`endif

/* hdl/aqcc_channel.v */
// Purpose: One channel's control line holder with legality checks.
// Assumes: Writes arrive one cycle long from the register decoder.
// Notes: Illegal codes are refused and the previous setting kept.
`timescale 1ns/1ps
`include "aqcc_map.vh"
module aqcc_channel #(
   parameter TEMP_PAD = 0
) (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire wr_en,
   input wire busy,
   input wire [6:0] wr_data,
   output reg [6:0] lines_reg,
   output reg reject_reg
);
   wire mux_bad;
   wire pre_bad;
   wire pol_bad;
   wire bad;
   assign mux_bad = (wr_data[`AQCC_MUX_MSB:`AQCC_MUX_LSB] == `AQCC_MUX_INVALID);
   assign pre_bad = (TEMP_PAD != 0) &&
      (wr_data[`AQCC_PRE_MSB:`AQCC_PRE_LSB] != `AQCC_PRE_16V) &&
      (wr_data[`AQCC_PRE_MSB:`AQCC_PRE_LSB] != `AQCC_PRE_4V);
   assign pol_bad = (TEMP_PAD != 0) && wr_data[`AQCC_POL_BIT];
   assign bad = mux_bad | pre_bad | pol_bad | busy;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lines_reg <= `AQCC_CTL_RESET;
         reject_reg <= 1'b0;
      end else if (clk_en && wr_en) begin
         reject_reg <= bad;
         if (!bad) begin
            lines_reg <= wr_data;
         end
      end
   end
endmodule // aqcc_channel

/* hdl/aqcc_quad.v */
// Purpose: APB-controlled control lines and temperature strobe for one analog quad.
// Assumes: APB master synchronous to core_clk; converter reports sampling done.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "aqcc_map.vh"
module aqcc_quad #(
   // Width of the sample-time register; the hold counter is one bit wider.
   parameter SAMPLE_W = 8
) (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   input wire adc_sample_done,
   input wire extest_active,
   input wire gate_drive_in,
   output wire [6:0] channel_control_lines_0,
   output wire [6:0] channel_control_lines_1,
   output wire [6:0] channel_control_lines_3,
   output reg temp_monitor_strobe,
   output reg excite_high_sel,
   output wire gate_drive_out,
   output wire gate_drive_oe,
   output wire gate_sink_en
);
   // One-hot states: idle, hold the strobe for the minimum time, wait for the converter.
   localparam ST_IDLE = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_WAIT = 3'b100;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   // The counter is one bit wider than the sample field so that the longest
   // hold time is still reached without wrapping.
   localparam [31:0] SETUP_CYC = {24'h000000, `AQCC_SETUP_CYC};
   reg [SAMPLE_W-1:0] sample_reg;
   reg [SAMPLE_W:0] cnt_reg;
   reg [SAMPLE_W:0] cnt_next;
   reg done_reg;
   reg req_reg;
   wire acc;
   wire wr;
   wire hit;
   wire busy;
   wire rej0;
   wire rej1;
   wire rej3;
   wire [SAMPLE_W:0] min_high;
   wire hit_ch0;
   wire hit_ch1;
   wire hit_ch3;
   wire hit_tctrl;
   wire hit_status;
   wire hit_sample;
   wire wr_ch0;
   wire wr_ch1;
   wire wr_ch3;
   wire wr_tctrl;
   wire wr_sample;
   wire rd_setup;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   // Every register answers in the same cycle, so no wait state is inserted.
   assign pready = 1'b1;
   assign hit_ch0 = (paddr == `AQCC_OFF_CH0);
   assign hit_ch1 = (paddr == `AQCC_OFF_CH1);
   assign hit_ch3 = (paddr == `AQCC_OFF_CH3);
   assign hit_tctrl = (paddr == `AQCC_OFF_TCTRL);
   assign hit_status = (paddr == `AQCC_OFF_STATUS);
   assign hit_sample = (paddr == `AQCC_OFF_SAMPLE);
   assign hit = hit_ch0 | hit_ch1 | hit_ch3 | hit_tctrl | hit_status | hit_sample;
   // Unmapped addresses raise an error, change nothing and read as zero.
   assign pslverr = acc & ~hit;
   // Writes take effect only in the access phase.
   assign wr_ch0 = wr & hit_ch0;
   assign wr_ch1 = wr & hit_ch1;
   assign wr_ch3 = wr & hit_ch3;
   assign wr_tctrl = wr & hit_tctrl;
   assign wr_sample = wr & hit_sample;
   // Read data is loaded in the setup cycle and stands through the access phase.
   assign rd_setup = clk_en & psel & ~penable & ~pwrite;
   assign busy = ~state_reg[0];
   // The strobe stays high for at least the programmed sample time plus the setup time plus two cycles.
   assign min_high = {1'b0, sample_reg} + SETUP_CYC[SAMPLE_W:0];
   // Voltage pad channel.
   aqcc_channel #(
      .TEMP_PAD(0)
   ) u_ch0 (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .wr_en(wr_ch0),
      .busy(busy),
      .wr_data(pwdata[6:0]),
      .lines_reg(channel_control_lines_0),
      .reject_reg(rej0)
   );
   // Current pad channel.
   aqcc_channel #(
      .TEMP_PAD(0)
   ) u_ch1 (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .wr_en(wr_ch1),
      .busy(busy),
      .wr_data(pwdata[6:0]),
      .lines_reg(channel_control_lines_1),
      .reject_reg(rej1)
   );
   // Temperature pad channel: range and polarity are restricted.
   aqcc_channel #(
      .TEMP_PAD(1)
   ) u_ch3 (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .wr_en(wr_ch3),
      .busy(busy),
      .wr_data(pwdata[6:0]),
      .lines_reg(channel_control_lines_3),
      .reject_reg(rej3)
   );
   // The pad drives only outside extest; during extest it becomes a weak sink.
   assign gate_drive_out = gate_drive_in;
   assign gate_drive_oe = ~extest_active;
   assign gate_sink_en = extest_active;
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = {(SAMPLE_W+1){1'b0}};
            if (req_reg) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Hold ends before the counter could wrap, so no saturation is needed.
            cnt_next = cnt_reg + {{SAMPLE_W{1'b0}}, 1'b1};
            if (cnt_reg >= min_high) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (adc_sample_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {(SAMPLE_W+1){1'b0}};
         sample_reg <= `AQCC_SAMPLE_RESET;
         req_reg <= 1'b0;
         done_reg <= 1'b0;
         temp_monitor_strobe <= 1'b0;
         excite_high_sel <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (wr_sample) begin
            sample_reg <= pwdata[SAMPLE_W-1:0];
         end
         // The request is one-shot; it clears once the strobe rises.
         if (wr_tctrl && pwdata[0]) begin
            req_reg <= 1'b1;
         end else if (state_reg == ST_HOLD) begin
            req_reg <= 1'b0;
         end
         // Done is set on completion and cleared by writing bit 1; set wins.
         if (state_reg == ST_WAIT && adc_sample_done) begin
            done_reg <= 1'b1;
         end else if (wr_tctrl && pwdata[1]) begin
            done_reg <= 1'b0;
         end
         // The excitation select follows the strobe, high while a reading runs.
         temp_monitor_strobe <= ~state_next[0];
         excite_high_sel <= ~state_next[0];
      end
   end
   // Read mux; unused upper bits read as zero.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `AQCC_OFF_CH0: prdata <= {25'h0000000, channel_control_lines_0};
            `AQCC_OFF_CH1: prdata <= {25'h0000000, channel_control_lines_1};
            `AQCC_OFF_CH3: prdata <= {25'h0000000, channel_control_lines_3};
            `AQCC_OFF_TCTRL: prdata <= {30'h00000000, done_reg, req_reg};
            `AQCC_OFF_STATUS: prdata <= {27'h0000000, rej3, rej1, rej0, busy, done_reg};
            `AQCC_OFF_SAMPLE: prdata <= {{(32-SAMPLE_W){1'b0}}, sample_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule // aqcc_quad

/* verification/aqcc_chk.sv */
// Purpose: Port assertions for the quad control block.
// Assumes: Bound to aqcc_quad by port name.
// Notes: One clock domain.
`timescale 1ns/1ps
module aqcc_chk (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire adc_sample_done,
   input wire extest_active,
   input wire [6:0] channel_control_lines_0,
   input wire [6:0] channel_control_lines_1,
   input wire [6:0] channel_control_lines_3,
   input wire temp_monitor_strobe,
   input wire excite_high_sel,
   input wire gate_sink_en
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire wr = psel && penable && pwrite && clk_en;
   wire [6:0] wd = pwdata[6:0];
   wire [6:0] c3 = channel_control_lines_3;
   excite_sel_a: assert property (excite_high_sel == temp_monitor_strobe)
      else $error("excite select off");
   sink_mode_a: assert property (gate_sink_en == extest_active) else $error("sink");
   mux_code_a: assert property (channel_control_lines_1[4:3] != 2'h3) else $error("mux");
   temp_range_a: assert property (c3[2:0] == 3'h0 || c3[2:0] == 3'h2)
      else $error("range");
   temp_pol_a: assert property (!c3[6]) else $error("polarity");
   ch0_load_a: assert property (wr && paddr == 12'h000 && wd[4:3] != 2'h3
      && !temp_monitor_strobe |=> channel_control_lines_0 == $past(wd)) else $error("load");
   strobe_start_a: assert property (wr && paddr == 12'h010 && pwdata[0]
      && !temp_monitor_strobe |-> ##2 temp_monitor_strobe) else $error("start");
   // Track the programmed sample time and how long the strobe has stood high.
   reg [7:0] samp_seen;
   reg [8:0] high_cnt;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         samp_seen <= 8'h10;
         high_cnt <= 9'h000;
      end else if (clk_en) begin
         if (wr && paddr == 12'h018) begin
            samp_seen <= pwdata[7:0];
         end
         high_cnt <= temp_monitor_strobe ? high_cnt + 9'h001 : 9'h000;
      end
   end
   strobe_min_a: assert property ($fell(temp_monitor_strobe) |->
      $past(high_cnt) >= {1'b0, samp_seen} + 9'h002) else $error("short");
   strobe_end_a: assert property ($fell(temp_monitor_strobe) |-> $past(adc_sample_done))
      else $error("early end");
   ctl_hold_a: assert property (!wr |=> $stable(channel_control_lines_1))
      else $error("moved");
   cover property ($fell(temp_monitor_strobe));
   cover property (wr && paddr == 12'h00C);
   cover property ($rose(gate_sink_en));
endmodule // aqcc_chk

/* verification/aqcc_adc_model.sv */
// Purpose: Converter side that answers a temperature strobe.
// Assumes: Done stays high until the strobe drops.
// Notes: The delay input gives prompt or slow answers.
`timescale 1ns/1ps
module aqcc_adc_model (
   input wire core_clk,
   input wire [7:0] delay,
   input wire temp_monitor_strobe,
   output reg adc_sample_done
);
   reg [8:0] cnt_reg = 9'h000;
   initial adc_sample_done = 1'b0;
   always @(posedge core_clk) begin
      cnt_reg <= temp_monitor_strobe ? cnt_reg + 9'h001 : 9'h000;
      adc_sample_done <= temp_monitor_strobe && cnt_reg >= {1'b0, delay};
   end
endmodule // aqcc_adc_model

/* verification/aqcc_quad_tb.sv */
// Purpose: Self-checking bench for the quad control block.
// Assumes: Zero-wait APB slave and a converter model on the far side.
// Notes: Scenarios run in sequence after reset.
`timescale 1ns/1ps
module aqcc_quad_tb;
   logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, extest_active = 1'b0, gate_drive_in = 1'b1, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [7:0] adc_delay = 8'h02;
   logic [6:0] v;
   integer bad_count = 0, total_checks = 0, i;
   wire pready, pslverr, adc_sample_done, temp_monitor_strobe, excite_high_sel;
   wire gate_drive_out, gate_drive_oe, gate_sink_en;
   wire [31:0] prdata;
   wire [6:0] channel_control_lines_0, channel_control_lines_1, channel_control_lines_3;
   always #20 core_clk = ~core_clk;
   aqcc_quad aqcc_quad_i (.*);
   aqcc_adc_model aqcc_adc_model_i (.core_clk(core_clk), .delay(adc_delay),
      .temp_monitor_strobe(temp_monitor_strobe), .adc_sample_done(adc_sample_done));
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
      if (n == 20) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task t_channels;
      chk("lines0 reset", 32'h0, channel_control_lines_0);
      for (i = 0; i < 8; i++) begin
         v = {i[0], i[1], 2'(i % 3), 3'(i)};
         apb(1'b1, 12'h000, {25'h0, v});
         chk("lines0", v, channel_control_lines_0);
      end
      apb(1'b1, 12'h004, 32'h55);
      chk("lines1", 32'h55, channel_control_lines_1);
      apb(1'b1, 12'h00C, 32'h32);
      chk("lines3", 32'h32, channel_control_lines_3);
      apb(1'b1, 12'h004, 32'h18);
      chk("lines1 kept", 32'h55, channel_control_lines_1);
      apb(1'b1, 12'h00C, 32'h01);
      apb(1'b1, 12'h00C, 32'h40);
      chk("lines3 kept", 32'h32, channel_control_lines_3);
      apb(1'b0, 12'h014, 32'h0);
      chk("reject flags", 32'h18, rd & 32'h1C);
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped err", 1, err);
   endtask
   task t_temp(input logic [7:0] samp, input logic [7:0] dly);
      integer n;
      integer want;
      want = (samp + 3 > dly + 2) ? samp + 3 : dly + 2;
      adc_delay <= dly;
      apb(1'b1, 12'h018, {24'h0, samp});
      apb(1'b0, 12'h018, 32'h0);
      chk("sample reg", {24'h0, samp}, rd);
      apb(1'b1, 12'h010, 32'h1);
      for (n = 0; temp_monitor_strobe !== 1'b1 && n < 9; n++) @(posedge core_clk);
      chk("strobe rise", 1, temp_monitor_strobe);
      for (n = 0; temp_monitor_strobe === 1'b1 && n < 300; n++) @(posedge core_clk);
      chk("strobe span", want, n);
      apb(1'b0, 12'h014, 32'h0);
      chk("status", 1, rd[1:0]);
      apb(1'b1, 12'h010, 32'h2);
      apb(1'b0, 12'h010, 32'h0);
      chk("done cleared", 0, rd);
   endtask
   task t_busy;
      integer n;
      apb(1'b1, 12'h010, 32'h1);
      @(posedge core_clk);
      chk("excite on", 1, excite_high_sel);
      apb(1'b1, 12'h000, 32'h05);
      chk("busy keep", 32'h6F, channel_control_lines_0);
      apb(1'b0, 12'h014, 32'h0);
      chk("busy status", 32'h6, rd & 32'h6);
      for (n = 0; temp_monitor_strobe === 1'b1 && n < 300; n++) @(posedge core_clk);
      chk("excite off", 0, excite_high_sel);
      apb(1'b1, 12'h010, 32'h2);
   endtask
   task t_freeze;
      clk_en <= 1'b0;
      apb(1'b1, 12'h004, 32'h0D);
      chk("frozen lines1", 32'h55, channel_control_lines_1);
      clk_en <= 1'b1;
      apb(1'b1, 12'h004, 32'h0D);
      chk("lines1 after", 32'h0D, channel_control_lines_1);
   endtask
   task t_extest;
      extest_active <= 1'b1;
      gate_drive_in <= 1'b0;
      @(posedge core_clk);
      chk("oe off", 0, gate_drive_oe);
      chk("sink on", 1, gate_sink_en);
      extest_active <= 1'b0;
      @(posedge core_clk);
      chk("pad drive", 1, gate_drive_oe && gate_drive_out === 1'b0);
   endtask
   task close_out;
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, 12'h018, 32'h0);
      chk("sample reg", 32'h10, rd);
      t_channels;
      t_temp(8'h10, 8'h02);
      t_busy;
      t_temp(8'h04, 8'h02);
      t_temp(8'h10, 8'h28);
      t_freeze;
      t_extest;
      close_out;
   end
   initial begin
      #200000;
      bad_count++;
      close_out;
   end
endmodule // aqcc_quad_tb
bind aqcc_quad aqcc_chk aqcc_chk_i (.*);
